// ==== design/anpd_defs.svh ====
`ifndef ANPD_DEFS_SVH
`define ANPD_DEFS_SVH

// Clock and timing.
`define ANPD_CLK_PERIOD_PS 5000
`define ANPD_RESP_WAIT_US 50
`define ANPD_RESP_WAIT_CYC ((`ANPD_RESP_WAIT_US * 1000000) / `ANPD_CLK_PERIOD_PS)
`define ANPD_WAIT_W 24

// Management register numbers.
`define ANPD_ADDR_W 5
`define ANPD_DATA_W 16
`define ANPD_REG_CTRL 5'h00
`define ANPD_REG_STAT 5'h01
`define ANPD_REG_ADV 5'h04
`define ANPD_REG_PART 5'h05
`define ANPD_REG_EXP 5'h06
`define ANPD_REG_CONS 5'h11
`define ANPD_REG_XSTAT 5'h13

// Control register fields.
`define ANPD_CTRL_SOFT_RESET 15
`define ANPD_CTRL_AN_ENABLE 12
`define ANPD_CTRL_RESTART 9

// Status register fields.
`define ANPD_STAT_COMPLETE 5
`define ANPD_STAT_RFAULT 4
`define ANPD_STAT_LINK 2

// Advertisement and partner ability fields.
`define ANPD_ABIL_RFAULT 13
`define ANPD_ABIL_TECH_HI 8
`define ANPD_ABIL_TECH_LO 5
`define ANPD_ADV_SELECTOR 5'h01
`define ANPD_ADV_TECH_RESET 4'hF

// Expansion register fields.
`define ANPD_EXP_PD_FAULT 4
`define ANPD_EXP_PARTNER_NEG 0

// Consolidated status register fields.
`define ANPD_CONS_SPEED 15
`define ANPD_CONS_DUPLEX 14
`define ANPD_CONS_PROG_HI 13
`define ANPD_CONS_PROG_LO 11
`define ANPD_CONS_COMPLETE 4
`define ANPD_CONS_NO_SIGNAL 3
`define ANPD_CONS_RFAULT 1
`define ANPD_CONS_LINK 0

// Extra status register fields.
`define ANPD_XSTAT_RFAULT 13

// Technology one-hot bits within the four-bit ability field.
`define ANPD_TECH_10HD 4'h1
`define ANPD_TECH_10FD 4'h2
`define ANPD_TECH_100HD 4'h4
`define ANPD_TECH_100FD 4'h8
`define ANPD_TECH_NONE 4'h0

// Progress codes.
`define ANPD_CODE_IDLE 4'h0
`define ANPD_CODE_TX_DISABLE 4'h1
`define ANPD_CODE_ABILITY 4'h2
`define ANPD_CODE_ACK 4'h3
`define ANPD_CODE_COMPLETE_ACK 4'h4
`define ANPD_CODE_PD_WAIT 4'h5
`define ANPD_CODE_LINK_CHECK 4'h6
`define ANPD_CODE_PD_FAULT 4'h7
`define ANPD_CODE_LINK_GOOD 4'h8
`define ANPD_CODE_DONE 4'hF

`endif

// ==== design/anpd_pkg.sv ====
`include "anpd_defs.svh"

package anpd_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_TX_DISABLE,
    ST_ABILITY,
    ST_ACK,
    ST_COMPLETE_ACK,
    ST_PD_WAIT,
    ST_LINK_CHECK,
    ST_PD_FAULT,
    ST_LINK_GOOD
  } anpd_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [`ANPD_ADDR_W-1:0] addr;
    logic [`ANPD_DATA_W-1:0] wdata;
  } anpd_bus_req_t;

  typedef struct packed {
    logic flp_seen;
    logic nlp_seen;
    logic idle_seen;
    logic energy_seen;
    logic link_up;
    logic partner_rf;
    logic local_fault;
    logic [3:0] partner_tech;
  } anpd_line_t;

endpackage

// ==== design/anpd_progress.sv ====
`timescale 1ns/1ps
`include "anpd_defs.svh"

module anpd_progress
  import anpd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  input wire logic read_in,
  input wire logic done_in,
  input wire logic [3:0] present_in,
  output logic [3:0] held_out
);

  logic frozen;

  // A read takes the present code; the old value was already sampled by the reader.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      held_out <= `ANPD_CODE_IDLE;
      frozen <= 1'b0;
    end
    else if (clear_in)
    begin
      held_out <= `ANPD_CODE_IDLE;
      frozen <= 1'b0;
    end
    else if (read_in)
    begin
      held_out <= present_in;
      frozen <= 1'b0;
    end
    else if (frozen)
    begin
      held_out <= held_out;
    end
    else if (done_in)
    begin
      held_out <= `ANPD_CODE_DONE;
      frozen <= 1'b1;
    end
    else if (present_in > held_out)
    begin
      held_out <= present_in;
    end
  end

endmodule

// ==== design/anpd_monitor.sv ====
`timescale 1ns/1ps
`include "anpd_defs.svh"

// Functional notes
// - No FLP answer clears partner-negotiates flag
// - Parallel detect sets 10HD or 100HD ability bit
// - Completion sets complete, enables only detected technology
// - Only normal link pulses selects 10Base-T
// - Scrambled idles select non-negotiating 100Base-TX
// - FLP answer sets partner-negotiates flag
// - No receive signal sets signal-detect bit
// - Several indications: no technology, set fault
// - Partner remote fault sets all remote-fault bits but the advertised one
// - Local link fault signalled and advertised
// - Negotiate at power-up and on request
// - Any reset idles machines, clears progress
// - Restart idles machines, keeps progress bits
// - After completion only read or reset change progress
// - Restart on link fail, restart bit, enable toggle
// - Speed, duplex, link, complete in consolidated register
// - Progress code is 17.4 then 17.13:11
// - Progress codes are 0h to 8h and Fh
// - Progress latches only a greater state
// - Read returns old code, then loads present
// - After success read Fh, then 8h
module anpd_monitor
  import anpd_pkg::*;
#(
  parameter int unsigned RESP_WAIT_CYC = `ANPD_RESP_WAIT_CYC
)
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire anpd_bus_req_t bus_in,
  output logic [`ANPD_DATA_W-1:0] rdata_out,
  input wire anpd_line_t line_in,
  output logic [3:0] tech_enable_out,
  output logic remote_fault_tx_out
);

  localparam logic [`ANPD_WAIT_W-1:0] WAIT_LAST = `ANPD_WAIT_W'(RESP_WAIT_CYC - 1);

  anpd_state_t state;
  logic an_enable;
  logic restart_req;
  logic soft_reset;
  logic start_pending;
  logic [`ANPD_WAIT_W-1:0] wait_cnt;
  logic [3:0] adv_tech;
  logic [3:0] partner_tech;
  logic [3:0] res_tech;
  logic partner_neg;
  logic pd_fault;
  logic rf_flag;
  logic complete;
  logic no_signal;
  logic done_pulse;
  logic [3:0] held_code;
  logic wr_ctrl;
  logic wr_adv;
  logic rd_stat;
  logic rd_cons;
  logic link_fail;
  logic restart_take;
  logic enable_rise;
  logic restart_evt;
  logic wait_over;
  logic [3:0] present_code;

  // Several technology indications at once cannot be resolved.
  function automatic logic multi_ind(input anpd_line_t ln);
    multi_ind = (ln.flp_seen & ln.nlp_seen) | (ln.flp_seen & ln.idle_seen) |
                (ln.nlp_seen & ln.idle_seen);
  endfunction

  // Highest-priority technology of a set, one-hot.
  function automatic logic [3:0] tech_best(input logic [3:0] t);
    if ((t & `ANPD_TECH_100FD) != `ANPD_TECH_NONE)
      tech_best = `ANPD_TECH_100FD;
    else if ((t & `ANPD_TECH_100HD) != `ANPD_TECH_NONE)
      tech_best = `ANPD_TECH_100HD;
    else if ((t & `ANPD_TECH_10FD) != `ANPD_TECH_NONE)
      tech_best = `ANPD_TECH_10FD;
    else if ((t & `ANPD_TECH_10HD) != `ANPD_TECH_NONE)
      tech_best = `ANPD_TECH_10HD;
    else
      tech_best = `ANPD_TECH_NONE;
  endfunction

  function automatic logic [3:0] state_code(input anpd_state_t s);
    unique case (s)
      ST_IDLE: state_code = `ANPD_CODE_IDLE;
      ST_TX_DISABLE: state_code = `ANPD_CODE_TX_DISABLE;
      ST_ABILITY: state_code = `ANPD_CODE_ABILITY;
      ST_ACK: state_code = `ANPD_CODE_ACK;
      ST_COMPLETE_ACK: state_code = `ANPD_CODE_COMPLETE_ACK;
      ST_PD_WAIT: state_code = `ANPD_CODE_PD_WAIT;
      ST_LINK_CHECK: state_code = `ANPD_CODE_LINK_CHECK;
      ST_PD_FAULT: state_code = `ANPD_CODE_PD_FAULT;
      ST_LINK_GOOD: state_code = `ANPD_CODE_LINK_GOOD;
      default: state_code = `ANPD_CODE_IDLE;
    endcase
  endfunction

  assign wr_ctrl = bus_in.wr && (bus_in.addr == `ANPD_REG_CTRL);
  assign wr_adv = bus_in.wr && (bus_in.addr == `ANPD_REG_ADV);
  assign rd_stat = bus_in.rd && (bus_in.addr == `ANPD_REG_STAT);
  assign rd_cons = bus_in.rd && (bus_in.addr == `ANPD_REG_CONS);
  assign present_code = state_code(state);
  assign wait_over = (wait_cnt == WAIT_LAST);
  assign link_fail = (state == ST_LINK_GOOD) && !line_in.link_up;
  assign restart_take = restart_req && an_enable;
  assign enable_rise = wr_ctrl && !an_enable && bus_in.wdata[`ANPD_CTRL_AN_ENABLE];
  assign restart_evt = link_fail || restart_take || enable_rise;

  // Control register: enable, self-clearing restart and software reset.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      an_enable <= 1'b1;
      soft_reset <= 1'b0;
    end
    else if (soft_reset)
    begin
      an_enable <= 1'b1;
      soft_reset <= 1'b0;
    end
    else
    begin
      soft_reset <= wr_ctrl && bus_in.wdata[`ANPD_CTRL_SOFT_RESET];
      if (wr_ctrl)
        an_enable <= bus_in.wdata[`ANPD_CTRL_AN_ENABLE];
    end
  end

  // A fresh write of the restart bit beats the clearing by the machine.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      restart_req <= 1'b0;
    else if (soft_reset)
      restart_req <= 1'b0;
    else if (wr_ctrl && bus_in.wdata[`ANPD_CTRL_RESTART])
      restart_req <= 1'b1;
    else if (restart_take || !an_enable)
      restart_req <= 1'b0;
  end

  // Advertised technologies.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      adv_tech <= `ANPD_ADV_TECH_RESET;
    else if (soft_reset)
      adv_tech <= `ANPD_ADV_TECH_RESET;
    else if (wr_adv)
      adv_tech <= bus_in.wdata[`ANPD_ABIL_TECH_HI:`ANPD_ABIL_TECH_LO];
  end

  // Request to start a negotiation, pending until the machine leaves idle.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      start_pending <= 1'b1;
    else if (soft_reset || restart_evt)
      start_pending <= 1'b1;
    else if (state == ST_IDLE && an_enable)
      start_pending <= 1'b0;
  end

  // Arbitration state machine; restart and reset both return it to idle.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state <= ST_IDLE;
    else if (soft_reset || restart_evt || !an_enable)
      state <= ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (start_pending)
            state <= ST_TX_DISABLE;
        end
        ST_TX_DISABLE:
          state <= ST_ABILITY;
        ST_ABILITY:
        begin
          if (multi_ind(line_in))
            state <= ST_PD_FAULT;
          else if (line_in.flp_seen)
            state <= ST_ACK;
          else if (line_in.nlp_seen || line_in.idle_seen)
            state <= ST_PD_WAIT;
          else if (wait_over)
            state <= ST_TX_DISABLE;
        end
        ST_ACK:
          state <= ST_COMPLETE_ACK;
        ST_COMPLETE_ACK:
          state <= ST_LINK_CHECK;
        ST_LINK_CHECK:
        begin
          if (line_in.link_up)
            state <= ST_LINK_GOOD;
          else if (wait_over)
            state <= ST_TX_DISABLE;
        end
        ST_PD_WAIT:
        begin
          if (multi_ind(line_in))
            state <= ST_PD_FAULT;
          else if (line_in.link_up)
            state <= ST_LINK_GOOD;
          else if (wait_over)
            state <= ST_TX_DISABLE;
        end
        ST_PD_FAULT:
          state <= ST_PD_FAULT;
        ST_LINK_GOOD:
          state <= ST_LINK_GOOD;
      endcase
    end
  end

  // Wait timer, running while the machine listens for an answer.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wait_cnt <= '0;
    else if (state == ST_ABILITY || state == ST_LINK_CHECK || state == ST_PD_WAIT)
      wait_cnt <= wait_over ? '0 : wait_cnt + `ANPD_WAIT_W'(1);
    else
      wait_cnt <= '0;
  end

  // Partner classification from the answer to the bursts.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      partner_neg <= 1'b0;
      partner_tech <= `ANPD_TECH_NONE;
      res_tech <= `ANPD_TECH_NONE;
    end
    else if (soft_reset)
    begin
      partner_neg <= 1'b0;
      partner_tech <= `ANPD_TECH_NONE;
      res_tech <= `ANPD_TECH_NONE;
    end
    else if (state == ST_ABILITY && !multi_ind(line_in))
    begin
      if (line_in.flp_seen)
      begin
        partner_neg <= 1'b1;
        partner_tech <= line_in.partner_tech;
        res_tech <= tech_best(adv_tech & line_in.partner_tech);
      end
      else if (line_in.nlp_seen)
      begin
        partner_neg <= 1'b0;
        partner_tech <= `ANPD_TECH_10HD;
        res_tech <= `ANPD_TECH_10HD;
      end
      else if (line_in.idle_seen)
      begin
        partner_neg <= 1'b0;
        partner_tech <= `ANPD_TECH_100HD;
        res_tech <= `ANPD_TECH_100HD;
      end
    end
  end

  // Completion and fault flags, and the done pulse for the progress code.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      complete <= 1'b0;
      pd_fault <= 1'b0;
      done_pulse <= 1'b0;
    end
    else if (soft_reset || restart_evt)
    begin
      complete <= 1'b0;
      pd_fault <= 1'b0;
      done_pulse <= 1'b0;
    end
    else
    begin
      done_pulse <= (state != ST_LINK_GOOD) && (state_code(state) != `ANPD_CODE_LINK_GOOD) &&
                    (state == ST_LINK_CHECK || state == ST_PD_WAIT) && line_in.link_up &&
                    !multi_ind(line_in);
      if (state == ST_LINK_GOOD)
        complete <= 1'b1;
      if (state == ST_PD_FAULT)
        pd_fault <= 1'b1;
    end
  end

  // Partner remote fault: sticky, cleared by reading status, set wins.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rf_flag <= 1'b0;
    else if (line_in.partner_rf)
      rf_flag <= 1'b1;
    else if (soft_reset || rd_stat)
      rf_flag <= 1'b0;
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      no_signal <= 1'b1;
      remote_fault_tx_out <= 1'b0;
      tech_enable_out <= `ANPD_TECH_NONE;
    end
    else
    begin
      no_signal <= !line_in.energy_seen;
      remote_fault_tx_out <= line_in.local_fault;
      tech_enable_out <= (state == ST_LINK_GOOD) ? res_tech : `ANPD_TECH_NONE;
    end
  end

  anpd_progress u_progress (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .clear_in(soft_reset),
    .read_in(rd_cons),
    .done_in(done_pulse),
    .present_in(present_code),
    .held_out(held_code)
  );

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_out <= '0;
    else if (!bus_in.rd)
      rdata_out <= '0;
    else
    begin
      rdata_out <= '0;
      unique case (bus_in.addr)
        `ANPD_REG_CTRL:
        begin
          rdata_out[`ANPD_CTRL_AN_ENABLE] <= an_enable;
          rdata_out[`ANPD_CTRL_RESTART] <= restart_req;
        end
        `ANPD_REG_STAT:
        begin
          rdata_out[`ANPD_STAT_COMPLETE] <= complete;
          rdata_out[`ANPD_STAT_RFAULT] <= rf_flag;
          rdata_out[`ANPD_STAT_LINK] <= line_in.link_up;
        end
        `ANPD_REG_ADV:
        begin
          rdata_out[`ANPD_ABIL_RFAULT] <= remote_fault_tx_out;
          rdata_out[`ANPD_ABIL_TECH_HI:`ANPD_ABIL_TECH_LO] <= adv_tech;
          rdata_out[4:0] <= `ANPD_ADV_SELECTOR;
        end
        `ANPD_REG_PART:
        begin
          rdata_out[`ANPD_ABIL_RFAULT] <= rf_flag;
          rdata_out[`ANPD_ABIL_TECH_HI:`ANPD_ABIL_TECH_LO] <= partner_tech;
        end
        `ANPD_REG_EXP:
        begin
          rdata_out[`ANPD_EXP_PD_FAULT] <= pd_fault;
          rdata_out[`ANPD_EXP_PARTNER_NEG] <= partner_neg;
        end
        `ANPD_REG_CONS:
        begin
          rdata_out[`ANPD_CONS_SPEED] <= (res_tech[3:2] != 2'h0) && complete;
          rdata_out[`ANPD_CONS_DUPLEX] <= (res_tech[3] | res_tech[1]) && complete;
          rdata_out[`ANPD_CONS_PROG_HI:`ANPD_CONS_PROG_LO] <= held_code[2:0];
          rdata_out[`ANPD_CONS_COMPLETE] <= held_code[3];
          rdata_out[`ANPD_CONS_NO_SIGNAL] <= no_signal;
          rdata_out[`ANPD_CONS_RFAULT] <= rf_flag;
          rdata_out[`ANPD_CONS_LINK] <= line_in.link_up;
        end
        `ANPD_REG_XSTAT:
          rdata_out[`ANPD_XSTAT_RFAULT] <= rf_flag;
        default:
          rdata_out <= '0;
      endcase
    end
  end

endmodule

// ==== verification/anpd_check_monitor.sv ====
`timescale 1ns/1ps
`include "anpd_defs.svh"

module anpd_check
  import anpd_pkg::*;
#(
  parameter int unsigned RESP_WAIT_CYC = 16
)
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire anpd_bus_req_t bus_in,
  input wire logic [`ANPD_DATA_W-1:0] rdata_out,
  input wire anpd_line_t line_in,
  input wire logic [3:0] tech_enable_out,
  input wire logic remote_fault_tx_out
);
  logic cons_rd;
  assign cons_rd = bus_in.rd && bus_in.addr == `ANPD_REG_CONS;
  default clocking dcb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  a_rdata_idle: assert property (
    !$past(bus_in.rd) |-> rdata_out == 16'h0000) else $error("rdata not zero");
  a_fault_tx: assert property (
    1'b1 |=> remote_fault_tx_out == $past(line_in.local_fault)) else $error("fault tx");
  a_tech_onehot: assert property (
    $onehot0(tech_enable_out)) else $error("tech not one-hot");
  a_link_drop: assert property (
    $fell(line_in.link_up) |-> ##[0:3] tech_enable_out == 4'h0) else $error("tech kept");
  a_speed_bits: assert property (
    cons_rd && tech_enable_out == `ANPD_TECH_100HD |=> rdata_out[15] && !rdata_out[14])
    else $error("speed or duplex");
  a_code_legal: assert property (
    $past(cons_rd) |-> {rdata_out[4], rdata_out[13:11]} <= 4'h8
    || {rdata_out[4], rdata_out[13:11]} == 4'hF) else $error("illegal code");
  a_rf_bits: assert property (
    cons_rd && line_in.partner_rf && $past(line_in.partner_rf) |=> rdata_out[1])
    else $error("remote fault bit");
  a_no_signal: assert property (
    cons_rd && !line_in.energy_seen && !$past(line_in.energy_seen) |=> rdata_out[3])
    else $error("no signal bit");
  a_link_mirror: assert property (
    cons_rd && line_in.link_up && $past(line_in.link_up) |=> rdata_out[0])
    else $error("link bit");
  cover property (tech_enable_out == `ANPD_TECH_10HD);
  cover property (tech_enable_out == `ANPD_TECH_100HD);
  cover property (tech_enable_out == `ANPD_TECH_100FD);
  cover property (remote_fault_tx_out);
endmodule

bind anpd_monitor anpd_check #(.RESP_WAIT_CYC(RESP_WAIT_CYC)) u_anpd_check (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .line_in(line_in), .tech_enable_out(tech_enable_out),
  .remote_fault_tx_out(remote_fault_tx_out));

// ==== verification/anpd_partner.sv ====
`timescale 1ns/1ps
`include "anpd_defs.svh"

// Modes: 0 silent, 1 link pulses, 2 idles, 3 bursts, 4 pulses and idles together.
module anpd_partner
  import anpd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [2:0] mode_in,
  input wire logic [7:0] delay_in,
  input wire logic rf_in,
  input wire logic lf_in,
  output anpd_line_t line_out
);
  logic [2:0] mode_q;
  logic [7:0] cnt;
  always_ff @(posedge mclk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      mode_q <= 3'h0;
      cnt <= 8'h00;
    end
    else
    begin
      mode_q <= mode_in;
      cnt <= (mode_in != mode_q) ? 8'h00 : cnt + {7'h00, cnt != 8'hFF};
    end
  // A change of mode drops the link, so the device sees a link failure.
  always_comb
  begin
    line_out = '0;
    line_out.flp_seen = mode_q == 3'h3;
    line_out.nlp_seen = mode_q == 3'h1 || mode_q == 3'h4;
    line_out.idle_seen = mode_q == 3'h2 || mode_q == 3'h4;
    line_out.energy_seen = mode_q != 3'h0;
    line_out.link_up = mode_q inside {3'h1, 3'h2, 3'h3} && cnt >= delay_in;
    line_out.partner_rf = rf_in;
    line_out.local_fault = lf_in;
    line_out.partner_tech = (mode_q == 3'h3) ? `ANPD_TECH_100FD : `ANPD_TECH_NONE;
  end
endmodule

// ==== verification/anpd_monitor_tb_top.sv ====
`timescale 1ns/1ps
`include "anpd_defs.svh"

module anpd_monitor_tb_top
  import anpd_pkg::*;
  ;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  anpd_bus_req_t bus = '0;
  logic [15:0] rdata;
  anpd_line_t line;
  logic [3:0] tech;
  logic rf_tx;
  logic [2:0] mode = 3'h0;
  logic [7:0] dly = 8'h08;
  logic rf = 1'b0;
  logic lf = 1'b0;
  int err_count = 0;
  int n_checks = 0;

  always #2.5 mclk_in = ~mclk_in;

  anpd_partner u_anpd_partner (.mclk_in(mclk_in), .resetn_in(resetn_in), .mode_in(mode),
    .delay_in(dly), .rf_in(rf), .lf_in(lf), .line_out(line));
  anpd_monitor #(.RESP_WAIT_CYC(16)) u_anpd_monitor (.mclk_in(mclk_in),
    .resetn_in(resetn_in), .bus_in(bus), .rdata_out(rdata), .line_in(line),
    .tech_enable_out(tech), .remote_fault_tx_out(rf_tx));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] m,
    input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(what, exp, d & m);
  endtask

  task automatic wait_tech(input logic [3:0] exp);
    for (int i = 0; i < 400 && tech !== exp; i++)
      @(negedge mclk_in);
    chk("tech", {12'h000, exp}, {12'h000, tech});
    if (tech !== exp)
      finish_test();
  endtask

  task automatic t_reset();
    rd_chk("ctrl", `ANPD_REG_CTRL, 16'h9200, 16'h1000);
    rd_chk("adv", `ANPD_REG_ADV, 16'h21FF, 16'h01E1);
    wr(5'h1F, 16'hFFFF);
    rd_chk("unmapped", 5'h1F, 16'hFFFF, 16'h0000);
    rd_chk("nosig", `ANPD_REG_CONS, 16'h0008, 16'h0008);
    $display("end reset");
  endtask

  task automatic t_nlp();
    @(posedge mclk_in);
    mode <= 3'h1;
    wr(`ANPD_REG_CTRL, 16'h1200);
    repeat (2) @(posedge mclk_in);
    rd_chk("restart", `ANPD_REG_CTRL, 16'h0200, 16'h0000);
    wait_tech(`ANPD_TECH_10HD);
    rd_chk("stat", `ANPD_REG_STAT, 16'h0024, 16'h0024);
    rd_chk("part10", `ANPD_REG_PART, 16'h01E0, 16'h0020);
    rd_chk("pneg0", `ANPD_REG_EXP, 16'h0011, 16'h0000);
    rd_chk("hist", `ANPD_REG_CONS, 16'hF819, 16'h3811);
    rd_chk("now", `ANPD_REG_CONS, 16'hF819, 16'h0011);
    repeat (20) @(posedge mclk_in);
    rd_chk("held", `ANPD_REG_CONS, 16'h3810, 16'h0010);
    $display("end nlp");
  endtask

  task automatic t_idle();
    @(posedge mclk_in);
    mode <= 3'h2;
    dly <= 8'h28;
    wr(`ANPD_REG_CTRL, 16'h0000);
    wr(`ANPD_REG_CTRL, 16'h1000);
    rd_chk("kept", `ANPD_REG_CONS, 16'h3810, 16'h0010);
    wait_tech(`ANPD_TECH_100HD);
    rd_chk("cons100", `ANPD_REG_CONS, 16'hF819, 16'hB811);
    rd_chk("part100", `ANPD_REG_PART, 16'h01E0, 16'h0080);
    $display("end idle");
  endtask

  task automatic t_flp();
    @(posedge mclk_in);
    mode <= 3'h3;
    dly <= 8'h04;
    wait_tech(`ANPD_TECH_100FD);
    rd_chk("pneg1", `ANPD_REG_EXP, 16'h0011, 16'h0001);
    rd_chk("fd100", `ANPD_REG_CONS, 16'hC001, 16'hC001);
    $display("end flp");
  endtask

  task automatic t_pdfault();
    logic [15:0] d;
    @(posedge mclk_in);
    mode <= 3'h4;
    d = 16'h0000;
    for (int i = 0; i < 100 && d[4] !== 1'b1; i++)
      rd(`ANPD_REG_EXP, d);
    chk("pdfault", 16'h0010, d & 16'h0010);
    if (d[4] !== 1'b1)
      finish_test();
    chk("pdtech", 16'h0000, {12'h000, tech});
    // The held code is 8 from the last success, so the lower fault code must not replace it.
    rd_chk("pdhist", `ANPD_REG_CONS, 16'h3810, 16'h0010);
    rd_chk("pdnow", `ANPD_REG_CONS, 16'h3810, 16'h3800);
    // A plain link-pulse partner after a negotiating one must clear the partner flag again.
    @(posedge mclk_in);
    mode <= 3'h1;
    wr(`ANPD_REG_CTRL, 16'h1200);
    wait_tech(`ANPD_TECH_10HD);
    rd_chk("pneg0b", `ANPD_REG_EXP, 16'h0011, 16'h0000);
    $display("end pdfault");
  endtask

  task automatic t_faults();
    @(posedge mclk_in);
    rf <= 1'b1;
    lf <= 1'b1;
    repeat (3) @(negedge mclk_in);
    chk("rftx", 16'h0001, {15'h0000, rf_tx});
    rd_chk("statrf", `ANPD_REG_STAT, 16'h0010, 16'h0010);
    rd_chk("partrf", `ANPD_REG_PART, 16'h2000, 16'h2000);
    rd_chk("consrf", `ANPD_REG_CONS, 16'h0002, 16'h0002);
    rd_chk("xstatrf", `ANPD_REG_XSTAT, 16'h2000, 16'h2000);
    rd_chk("advrf", `ANPD_REG_ADV, 16'h2000, 16'h2000);
    @(posedge mclk_in);
    rf <= 1'b0;
    lf <= 1'b0;
    mode <= 3'h0;
    $display("end faults");
  endtask

  task automatic t_soft();
    wr(`ANPD_REG_ADV, 16'h0001);
    rd_chk("advrw", `ANPD_REG_ADV, 16'h01E0, 16'h0000);
    wr(`ANPD_REG_CTRL, 16'h9000);
    repeat (3) @(posedge mclk_in);
    rd_chk("advrst", `ANPD_REG_ADV, 16'h21FF, 16'h01E1);
    rd_chk("ctrlsc", `ANPD_REG_CTRL, 16'h8000, 16'h0000);
    rd_chk("codeclr", `ANPD_REG_CONS, 16'h2010, 16'h0000);
    $display("end soft");
  endtask

  initial
  begin
    repeat (5) @(posedge mclk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_nlp();
    t_idle();
    t_flp();
    t_pdfault();
    t_faults();
    t_soft();
    finish_test();
  end
endmodule
